// File: common/scs_pkg.sv
// Package of constants, types and register map for the curtain status indicator
//
// Behaviour
// (R1) First indicator: steady red when safety outputs off, green when on, dark unpowered.
// (R2) First indicator flashes red 1 Hz on external fault, 10 Hz on internal.
// (R3) First indicator flashes green 1 Hz when outputs on but signal weak.
// (R4) Second indicator dark: interlock disabled, released, or locked with field interrupted.
// (R5) Second indicator steady yellow when interlock locked but ready to release.
// (R6) Second indicator flashes yellow while upstream circuit open; 1x/2x on changeover.
// (R7) Third indicator dark when no special function is active.
// (R8) Third indicator steady blue once blanking field parameters were taught.
// (R9) Third indicator flashes blue 1 Hz while muting is active.
// (R10) Third indicator short blue flashes: teach required, muting restart, override.
// (R11) Third indicator flashes blue 10 Hz on teaching error.
// (R12) First supply high, second low selects the first optical channel.
// (R13) First supply low, second high selects the second optical channel.
package scs_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned SLOW_FLASH_HZ = 1;
  localparam int unsigned FAST_FLASH_HZ = 10;
  localparam int unsigned SLOW_HALF_CYC = CLK_HZ / (2 * SLOW_FLASH_HZ);
  localparam int unsigned FAST_HALF_CYC = CLK_HZ / (2 * FAST_FLASH_HZ);
  localparam int unsigned HALF_W = 24;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CHG = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h10;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h14;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [2:0] IRQ_EN_RESET = 3'h0;

  // ----------------------------------------
  // Interrupt bits
  // ----------------------------------------
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_CH_CHANGE = 0;
  localparam int unsigned IRQ_SUPPLY_BAD = 1;
  localparam int unsigned IRQ_CHG_DONE = 2;

  // ----------------------------------------
  // Field encodings
  // ----------------------------------------
  typedef enum logic [1:0] {
    FAULT_NONE = 2'h0,
    FAULT_EXT = 2'h1,
    FAULT_INT = 2'h2
  } scs_fault_e;

  typedef enum logic [1:0] {
    RI_DISABLED = 2'h0,
    RI_RELEASED = 2'h1,
    RI_LOCKED_BLOCKED = 2'h2,
    RI_LOCKED_READY = 2'h3
  } scs_interlock_e;

  typedef enum logic [2:0] {
    SP_NONE = 3'h0,
    SP_TAUGHT = 3'h1,
    SP_MUTING = 3'h2,
    SP_TEACH_REQ = 3'h3,
    SP_MUTE_RESTART = 3'h4,
    SP_OVERRIDE = 3'h5,
    SP_TEACH_ERR = 3'h6
  } scs_special_e;

  typedef enum logic [3:0] {
    CHG_IDLE = 4'h1,
    CHG_ALIGN = 4'h2,
    CHG_ON = 4'h4,
    CHG_OFF = 4'h8
  } scs_chg_e;

  // ----------------------------------------
  // Register layouts
  // ----------------------------------------
  typedef struct packed {
    logic [20:0] rsvd;
    scs_special_e special;
    logic upstream_open;
    scs_interlock_e interlock;
    scs_fault_e fault;
    logic weak_signal;
    logic safety_switch_output;
    logic powered;
  } scs_ctrl_s;

  typedef struct packed {
    logic red;
    logic green;
    logic yellow;
    logic blue;
  } scs_led_s;

  typedef struct packed {
    logic [24:0] rsvd;
    logic chg_busy;
    logic optical_channel_second;
    logic optical_channel_first;
    scs_led_s led;
  } scs_status_s;

  localparam int unsigned CHG_CNT_W = 2;

endpackage : scs_pkg

// File: hdl/scs_sync.sv
// Two-stage synchroniser for pin inputs
module scs_sync
  import scs_pkg::*;
#(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else if (ce) begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end

  assign q = sync_ff;

endmodule : scs_sync

// File: hdl/scs_flash.sv
// Square-wave flash timebase with a pulse at each rising half
module scs_flash
  import scs_pkg::*;
#(
  parameter int unsigned HALF = 10
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  output logic lvl,
  output logic tick
);

  localparam logic [HALF_W-1:0] LAST = HALF_W'(HALF - 1);

  logic [HALF_W-1:0] cnt_ff;
  logic lvl_ff;
  logic tick_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff <= '0;
      lvl_ff <= 1'b0;
      tick_ff <= 1'b0;
    end else if (ce) begin
      tick_ff <= 1'b0;
      if (cnt_ff == LAST) begin
        cnt_ff <= '0;
        lvl_ff <= ~lvl_ff;
        tick_ff <= ~lvl_ff;
      end else begin
        cnt_ff <= cnt_ff + 1'b1;
      end
    end
  end

  assign lvl = lvl_ff;
  assign tick = tick_ff;

endmodule : scs_flash

// File: hdl/scs_top.sv
// Status indicators and optical channel selection with AHB-Lite registers
//
// The implementer's own choices: register access over AHB-Lite and the address map.
module scs_top
  import scs_pkg::*;
#(
  parameter int unsigned SLOW_HALF = SLOW_HALF_CYC,
  parameter int unsigned FAST_HALF = FAST_HALF_CYC
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic CE,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic SUPPLY_SELECT_FIRST,
  input wire logic SUPPLY_SELECT_SECOND,
  output logic OPTICAL_CHANNEL_FIRST,
  output logic OPTICAL_CHANNEL_SECOND,
  output logic LED1_RED,
  output logic LED1_GREEN,
  output logic LED2_YELLOW,
  output logic LED3_BLUE,
  output logic IRQ
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [1:0] supply_sync;

  scs_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk(CLOCK),
    .rst(RST),
    .ce(CE),
    .d({SUPPLY_SELECT_SECOND, SUPPLY_SELECT_FIRST}),
    .q(supply_sync)
  );

  // ----------------------------------------
  // Flash timebases
  // ----------------------------------------
  logic slow_lvl;
  logic slow_tick;
  logic fast_lvl;
  logic fast_tick;

  scs_flash #(
    .HALF(SLOW_HALF)
  ) u_slow (
    .clk(CLOCK),
    .rst(RST),
    .ce(CE),
    .lvl(slow_lvl),
    .tick(slow_tick)
  );

  scs_flash #(
    .HALF(FAST_HALF)
  ) u_fast (
    .clk(CLOCK),
    .rst(RST),
    .ce(CE),
    .lvl(fast_lvl),
    .tick(fast_tick)
  );

  // ----------------------------------------
  // Bus address phase capture
  // ----------------------------------------
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic rd_take;
  logic wr_take;
  logic [31:0] nxt_rdata;
  logic [31:0] rdata_ff;

  assign rd_take = HSEL && HTRANS[1] && HREADY && !HWRITE;
  assign wr_take = HSEL && HTRANS[1] && HREADY && HWRITE;

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end else if (CE) begin
      wr_pend_ff <= wr_take;
      if (wr_take) begin
        wr_addr_ff <= HADDR[7:0];
      end
    end
  end

  logic wr_ctrl;
  logic wr_chg;
  logic wr_irq_en;
  logic wr_irq_clr;

  assign wr_ctrl = wr_pend_ff && (wr_addr_ff == ADDR_CTRL);
  assign wr_chg = wr_pend_ff && (wr_addr_ff == ADDR_CHG);
  assign wr_irq_en = wr_pend_ff && (wr_addr_ff == ADDR_IRQ_EN);
  assign wr_irq_clr = wr_pend_ff && (wr_addr_ff == ADDR_IRQ_CLR);

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  scs_ctrl_s ctrl_ff;

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ctrl_ff <= scs_ctrl_s'(CTRL_RESET);
    end else if (CE && wr_ctrl) begin
      ctrl_ff <= scs_ctrl_s'(HWDATA);
      ctrl_ff.rsvd <= '0;
    end
  end

  // ----------------------------------------
  // Changeover flash sequencer
  // ----------------------------------------
  scs_chg_e chg_state_ff;
  scs_chg_e nxt_chg_state;
  logic [CHG_CNT_W-1:0] chg_left_ff;
  logic [CHG_CNT_W-1:0] nxt_chg_left;
  logic [CHG_CNT_W-1:0] chg_req;
  logic chg_done;

  // Counts of 3 saturate to two flashes
  assign chg_req = (HWDATA[CHG_CNT_W-1:0] == 2'h3) ? 2'h2 : HWDATA[CHG_CNT_W-1:0];

  always_comb begin
    nxt_chg_state = chg_state_ff;
    nxt_chg_left = chg_left_ff;
    chg_done = 1'b0;
    case (chg_state_ff)
      CHG_IDLE: begin
        if (wr_chg && (chg_req != 2'h0)) begin // R6
          nxt_chg_state = CHG_ALIGN;
          nxt_chg_left = chg_req;
        end
      end
      CHG_ALIGN: begin
        if (fast_tick) begin
          nxt_chg_state = CHG_ON;
        end
      end
      CHG_ON: begin
        if (fast_tick) begin
          nxt_chg_state = CHG_OFF;
          nxt_chg_left = chg_left_ff - 1'b1;
        end
      end
      CHG_OFF: begin
        if (fast_tick) begin
          if (chg_left_ff == 2'h0) begin
            nxt_chg_state = CHG_IDLE;
            chg_done = 1'b1;
          end else begin
            nxt_chg_state = CHG_ON;
          end
        end
      end
      default: begin
        nxt_chg_state = CHG_IDLE;
        nxt_chg_left = 2'h0;
      end
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      chg_state_ff <= CHG_IDLE;
      chg_left_ff <= 2'h0;
    end else if (CE) begin
      chg_state_ff <= nxt_chg_state;
      chg_left_ff <= nxt_chg_left;
    end
  end

  // ----------------------------------------
  // Short flash window
  // ----------------------------------------
  logic short_ff;

  // Lit from a slow period start until the next fast tick
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      short_ff <= 1'b0;
    end else if (CE) begin
      if (slow_tick) begin
        short_ff <= 1'b1;
      end else if (fast_tick) begin
        short_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Indicator patterns
  // ----------------------------------------
  scs_led_s nxt_led;
  scs_led_s led_ff;

  always_comb begin
    nxt_led = '0;
    if (ctrl_ff.powered) begin
      if (ctrl_ff.fault == FAULT_INT) begin
        nxt_led.red = fast_lvl; // R2
      end else if (ctrl_ff.fault == FAULT_EXT) begin
        nxt_led.red = slow_lvl; // R2
      end else if (ctrl_ff.safety_switch_output && ctrl_ff.weak_signal) begin
        nxt_led.green = slow_lvl; // R3
      end else if (ctrl_ff.safety_switch_output) begin
        nxt_led.green = 1'b1; // R1
      end else begin
        nxt_led.red = 1'b1; // R1
      end
      if (chg_state_ff == CHG_ON) begin
        nxt_led.yellow = 1'b1; // R6
      end else if (chg_state_ff != CHG_IDLE) begin
        nxt_led.yellow = 1'b0; // R6
      end else if (ctrl_ff.upstream_open) begin
        nxt_led.yellow = slow_lvl; // R6
      end else if (ctrl_ff.interlock == RI_LOCKED_READY) begin
        nxt_led.yellow = 1'b1; // R5
      end else begin
        nxt_led.yellow = 1'b0; // R4
      end
      case (ctrl_ff.special)
        SP_NONE: nxt_led.blue = 1'b0; // R7
        SP_TAUGHT: nxt_led.blue = 1'b1; // R8
        SP_MUTING: nxt_led.blue = slow_lvl; // R9
        SP_TEACH_REQ: nxt_led.blue = short_ff; // R10
        SP_MUTE_RESTART: nxt_led.blue = short_ff; // R10
        SP_OVERRIDE: nxt_led.blue = short_ff; // R10
        SP_TEACH_ERR: nxt_led.blue = fast_lvl; // R11
        default: nxt_led.blue = 1'b0; // R7
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      led_ff <= '0;
    end else if (CE) begin
      led_ff <= nxt_led; // R1
    end
  end

  // ----------------------------------------
  // Optical channel selection
  // ----------------------------------------
  logic ch_first_ff;
  logic ch_second_ff;
  logic supply_bad_ff;
  logic nxt_ch_first;
  logic nxt_ch_second;
  logic nxt_supply_bad;

  assign nxt_ch_first = supply_sync[0] && !supply_sync[1]; // R12
  assign nxt_ch_second = !supply_sync[0] && supply_sync[1]; // R13
  assign nxt_supply_bad = !(nxt_ch_first || nxt_ch_second);

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ch_first_ff <= 1'b0;
      ch_second_ff <= 1'b0;
      supply_bad_ff <= 1'b0;
    end else if (CE) begin
      ch_first_ff <= nxt_ch_first; // R12
      ch_second_ff <= nxt_ch_second; // R13
      supply_bad_ff <= nxt_supply_bad;
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  logic [IRQ_W-1:0] irq_stat_ff;
  logic [IRQ_W-1:0] irq_en_ff;
  logic [IRQ_W-1:0] irq_ev;
  logic [IRQ_W-1:0] irq_clr;
  logic irq_ff;

  always_comb begin
    irq_ev = '0;
    irq_ev[IRQ_CH_CHANGE] = ((nxt_ch_first != ch_first_ff) || (nxt_ch_second != ch_second_ff))
      && !nxt_supply_bad;
    irq_ev[IRQ_SUPPLY_BAD] = nxt_supply_bad && !supply_bad_ff;
    irq_ev[IRQ_CHG_DONE] = chg_done;
  end

  assign irq_clr = wr_irq_clr ? HWDATA[IRQ_W-1:0] : '0;

  // Set wins over a clear in the same cycle
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      irq_stat_ff <= '0;
    end else if (CE) begin
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_ev;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      irq_en_ff <= IRQ_EN_RESET;
    end else if (CE && wr_irq_en) begin
      irq_en_ff <= HWDATA[IRQ_W-1:0];
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      irq_ff <= 1'b0;
    end else if (CE) begin
      irq_ff <= |(((irq_stat_ff & ~irq_clr) | irq_ev) & irq_en_ff);
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  scs_status_s status;

  always_comb begin
    status = '0;
    status.led = led_ff;
    status.optical_channel_first = ch_first_ff;
    status.optical_channel_second = ch_second_ff;
    status.chg_busy = (chg_state_ff != CHG_IDLE);
  end

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (HADDR[7:0])
      ADDR_CTRL: nxt_rdata = ctrl_ff;
      ADDR_STATUS: nxt_rdata = status;
      ADDR_IRQ_STAT: nxt_rdata = {29'h0000_0000, irq_stat_ff};
      ADDR_IRQ_EN: nxt_rdata = {29'h0000_0000, irq_en_ff};
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      rdata_ff <= 32'h0000_0000;
    end else if (CE) begin
      if (rd_take) begin
        rdata_ff <= nxt_rdata;
      end else begin
        rdata_ff <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------
  // Bus response
  // ----------------------------------------
  logic readyout_ff;
  logic resp_ff;

  // Zero wait states, always OKAY
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      readyout_ff <= 1'b1;
      resp_ff <= 1'b0;
    end else if (CE) begin
      readyout_ff <= 1'b1;
      resp_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign HRDATA = rdata_ff;
  assign HREADYOUT = readyout_ff;
  assign HRESP = resp_ff;
  assign OPTICAL_CHANNEL_FIRST = ch_first_ff;
  assign OPTICAL_CHANNEL_SECOND = ch_second_ff;
  assign LED1_RED = led_ff.red;
  assign LED1_GREEN = led_ff.green;
  assign LED2_YELLOW = led_ff.yellow;
  assign LED3_BLUE = led_ff.blue;
  assign IRQ = irq_ff;

endmodule : scs_top

// File: tb/scs_top_monitor.sv
// Concurrent checks on the status indicator ports
module scs_top_monitor
  import scs_pkg::*;
#(
  parameter int unsigned SLOW_HALF = SLOW_HALF_CYC,
  parameter int unsigned FAST_HALF = FAST_HALF_CYC
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic CE,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic SUPPLY_SELECT_FIRST,
  input wire logic SUPPLY_SELECT_SECOND,
  input wire logic OPTICAL_CHANNEL_FIRST,
  input wire logic OPTICAL_CHANNEL_SECOND,
  input wire logic LED1_RED,
  input wire logic LED1_GREEN,
  input wire logic LED2_YELLOW,
  input wire logic LED3_BLUE
);
  timeunit 1ns;
  timeprecision 1ns;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic [31:0] age;
  scs_ctrl_s sh;
  scs_ctrl_s cq;
  logic quiet;

  // Shadow of the control word, delayed to line up with the indicators
  assign quiet = age > 32'(8 * FAST_HALF);
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      age <= 32'h0000_0000;
      sh <= '0;
      cq <= '0;
    end else if (CE) begin
      wr_pend <= HSEL && HTRANS[1] && HWRITE && HREADY;
      wr_addr <= HADDR[7:0];
      cq <= sh;
      if (wr_pend && wr_addr == ADDR_CTRL) sh <= HWDATA;
      if (wr_pend && wr_addr == ADDR_CHG) age <= 32'h0000_0000;
      else if (age != 32'hFFFF_FFFF) age <= age + 32'h0000_0001;
    end
  end

  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);

  sequence s_pins_first;
    (!RST && CE && SUPPLY_SELECT_FIRST && !SUPPLY_SELECT_SECOND) [*3];
  endsequence
  sequence s_pins_second;
    (!RST && CE && !SUPPLY_SELECT_FIRST && SUPPLY_SELECT_SECOND) [*3];
  endsequence

  a_unpowered_dark:
    assert property (!cq.powered |-> !(LED1_RED || LED1_GREEN || LED2_YELLOW || LED3_BLUE))
    else $error("indicator lit while unpowered");
  a_red_when_off:
    assert property (cq.powered && cq.fault == FAULT_NONE && !cq.safety_switch_output
      |-> LED1_RED && !LED1_GREEN) else $error("first indicator not steady red");
  a_green_when_on:
    assert property (cq.powered && cq.fault == FAULT_NONE && cq.safety_switch_output
      && !cq.weak_signal |-> LED1_GREEN && !LED1_RED) else $error("first indicator not green");
  a_yellow_ready:
    assert property (quiet && cq.powered && !cq.upstream_open
      && cq.interlock == RI_LOCKED_READY |-> LED2_YELLOW) else $error("second indicator dark");
  a_yellow_dark:
    assert property (quiet && cq.powered && !cq.upstream_open
      && cq.interlock != RI_LOCKED_READY |-> !LED2_YELLOW) else $error("second indicator lit");
  a_blue_dark:
    assert property (cq.special == SP_NONE |-> !LED3_BLUE) else $error("third indicator lit");
  a_blue_steady:
    assert property (cq.powered && cq.special == SP_TAUGHT |-> LED3_BLUE)
    else $error("third indicator not steady");
  a_channel_first:
    assert property (s_pins_first |=> OPTICAL_CHANNEL_FIRST && !OPTICAL_CHANNEL_SECOND)
    else $error("first channel not selected");
  a_channel_second:
    assert property (s_pins_second |=> !OPTICAL_CHANNEL_FIRST && OPTICAL_CHANNEL_SECOND)
    else $error("second channel not selected");
endmodule : scs_top_monitor

bind scs_top scs_top_monitor #(.SLOW_HALF(SLOW_HALF), .FAST_HALF(FAST_HALF)) i_mon (
  .CLOCK(CLOCK), .RST(RST), .CE(CE), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY),
  .SUPPLY_SELECT_FIRST(SUPPLY_SELECT_FIRST), .SUPPLY_SELECT_SECOND(SUPPLY_SELECT_SECOND),
  .OPTICAL_CHANNEL_FIRST(OPTICAL_CHANNEL_FIRST), .OPTICAL_CHANNEL_SECOND(OPTICAL_CHANNEL_SECOND),
  .LED1_RED(LED1_RED), .LED1_GREEN(LED1_GREEN), .LED2_YELLOW(LED2_YELLOW), .LED3_BLUE(LED3_BLUE));

// File: tb/scs_wiring.sv
// Machine wiring model feeding the two supply select pins
module scs_wiring (
  input wire logic [1:0] sel,
  output logic supply_first,
  output logic supply_second
);
  timeunit 1ns;
  timeprecision 1ns;
  assign supply_first = sel[0];
  assign supply_second = sel[1];
endmodule : scs_wiring

// File: tb/scs_top_bench.sv
// Self-checking bench for the curtain status indicator
module scs_top_bench
  import scs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SH = 20;
  localparam int FH = 4;
  logic CLOCK = 1'b0;
  logic RST = 1'b1;
  logic CE = 1'b1;
  logic HSEL = 1'b0;
  logic HWRITE = 1'b0;
  logic [1:0] HTRANS = 2'h0;
  logic [2:0] HSIZE = 3'h2;
  logic [31:0] HADDR = 32'h0;
  logic [31:0] HWDATA = 32'h0;
  logic [1:0] pin_sel = 2'h1;
  logic HREADY, HREADYOUT, HRESP, IRQ, sup1, sup2, ch1, ch2;
  logic LED1_RED, LED1_GREEN, LED2_YELLOW, LED3_BLUE;
  logic [31:0] HRDATA;
  logic [31:0] rdat;
  logic [3:0] leds;
  int bad_count = 0;
  int compares = 0;

  assign HREADY = HREADYOUT;
  assign leds = {LED1_RED, LED1_GREEN, LED2_YELLOW, LED3_BLUE};
  always #25 CLOCK = ~CLOCK;

  scs_wiring i_wire (.sel(pin_sel), .supply_first(sup1), .supply_second(sup2));
  scs_top #(.SLOW_HALF(SH), .FAST_HALF(FH)) i_dut (.CLOCK(CLOCK), .RST(RST), .CE(CE),
    .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
    .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .SUPPLY_SELECT_FIRST(sup1), .SUPPLY_SELECT_SECOND(sup2), .OPTICAL_CHANNEL_FIRST(ch1),
    .OPTICAL_CHANNEL_SECOND(ch2), .LED1_RED(LED1_RED), .LED1_GREEN(LED1_GREEN),
    .LED2_YELLOW(LED2_YELLOW), .LED3_BLUE(LED3_BLUE), .IRQ(IRQ));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
    HSEL <= 1'b1;
    HADDR <= {24'h000000, a};
    HTRANS <= 2'h2;
    HWRITE <= w;
    do @(posedge CLOCK); while (HREADY !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CLOCK); while (HREADY !== 1'b1);
    rdat = HRDATA;
  endtask : ahb

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string n);
    ahb(a, 1'b0, 32'h0);
    chk(n, e, rdat);
    chk("bus response", 32'h0, 32'(HRESP));
  endtask : rchk

  // Modes: 0 dark, 1 steady, 2 slow, 3 fast, 4 short
  function automatic logic [11:0] exp_modes(scs_ctrl_s c);
    logic [2:0] r, g, y, b;
    {r, g, y, b} = 12'h000;
    if (c.powered) begin
      if (c.fault == FAULT_INT) r = 3'h3;
      else if (c.fault == FAULT_EXT) r = 3'h2;
      else if (!c.safety_switch_output) r = 3'h1;
      else g = c.weak_signal ? 3'h2 : 3'h1;
      if (c.upstream_open) y = 3'h2;
      else if (c.interlock == RI_LOCKED_READY) y = 3'h1;
      case (c.special)
        SP_NONE: b = 3'h0;
        SP_TAUGHT: b = 3'h1;
        SP_MUTING: b = 3'h2;
        SP_TEACH_ERR: b = 3'h3;
        SP_TEACH_REQ, SP_MUTE_RESTART, SP_OVERRIDE: b = 3'h4;
        default: b = 3'h0;
      endcase
    end
    return {r, g, y, b};
  endfunction : exp_modes

  function automatic logic [2:0] mode_of(int hi, int ri);
    if (hi == 0) return 3'h0;
    if (hi == 4 * SH) return 3'h1;
    if (hi == 2 * SH && ri == 2) return 3'h2;
    if (hi == 2 * SH && ri == 2 * SH / FH) return 3'h3;
    return 3'h4;
  endfunction : mode_of

  // Two slow periods of high time and rising edges per indicator
  task automatic probe(output logic [11:0] m);
    int hi[4];
    int ri[4];
    logic [3:0] p;
    logic [3:0] v;
    hi = '{0, 0, 0, 0};
    ri = '{0, 0, 0, 0};
    p = leds;
    repeat (4 * SH) begin
      @(posedge CLOCK);
      v = leds;
      for (int j = 0; j < 4; j++) begin
        hi[j] += int'(p[j]);
        ri[j] += int'(v[j] && !p[j]);
      end
      p = v;
    end
    for (int j = 0; j < 4; j++) m[3 * j +: 3] = mode_of(hi[j], ri[j]);
  endtask : probe

  task automatic tally_and_finish;
    if (bad_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    #(50 * 20000);
    bad_count++;
    tally_and_finish();
  end

  initial begin
    scs_ctrl_s c;
    logic [11:0] m;
    int r;
    logic p;
    void'($urandom(82));
    repeat (3) @(posedge CLOCK);
    RST <= 1'b0;
    @(posedge CLOCK);
    chk("leds after reset", 32'h0, 32'(leds));
    rchk(ADDR_CTRL, 32'h0, "ctrl reset");
    rchk(ADDR_IRQ_EN, 32'h0, "irq enable reset");
    ahb(8'h20, 1'b1, 32'hFFFF_FFFF);
    rchk(8'h20, 32'h0, "unmapped read");
    rchk(ADDR_CTRL, 32'h0, "ctrl untouched");
    for (int s = 0; s < 4; s++) begin
      pin_sel <= 2'(s);
      repeat (6) @(posedge CLOCK);
      chk("channel first", 32'(s == 1), 32'(ch1));
      chk("channel second", 32'(s == 2), 32'(ch2));
      rchk(ADDR_STATUS, 32'({s == 2, s == 1}) << 4, "status channel");
    end
    ahb(ADDR_IRQ_CLR, 1'b1, 32'h7);
    ahb(ADDR_IRQ_EN, 1'b1, 32'h1);
    pin_sel <= 2'h1;
    repeat (8) @(posedge CLOCK);
    chk("irq raised", 32'h1, 32'(IRQ));
    rchk(ADDR_IRQ_STAT, 32'h1, "irq status");
    ahb(ADDR_IRQ_EN, 1'b1, 32'h0);
    repeat (2) @(posedge CLOCK);
    chk("irq masked", 32'h0, 32'(IRQ));
    ahb(ADDR_IRQ_EN, 1'b1, 32'h1);
    ahb(ADDR_IRQ_CLR, 1'b1, 32'h1);
    repeat (2) @(posedge CLOCK);
    chk("irq cleared", 32'h0, 32'(IRQ));
    rchk(ADDR_IRQ_STAT, 32'h0, "status cleared");
    CE <= 1'b0;
    pin_sel <= 2'h0;
    repeat (6) @(posedge CLOCK);
    chk("frozen channel", 32'h1, 32'(ch1));
    CE <= 1'b1;
    repeat (6) @(posedge CLOCK);
    rchk(ADDR_IRQ_STAT, 32'h2, "supply bad flag");
    ahb(ADDR_IRQ_CLR, 1'b1, 32'h7);
    pin_sel <= 2'h2;
    repeat (6) @(posedge CLOCK);
    rchk(ADDR_IRQ_STAT, 32'h1, "second channel flag");
    for (int i = 0; i < 28; i++) begin
      c = scs_ctrl_s'($urandom);
      c.rsvd = '0;
      c.special = scs_special_e'(i % 7);
      c.interlock = scs_interlock_e'(i % 4);
      c.fault = scs_fault_e'(i % 3);
      c.powered = (i % 5 != 0);
      if (i < 12) begin
        {c.weak_signal, c.safety_switch_output} = 2'(i);
        c.upstream_open = i[2];
      end
      ahb(ADDR_CTRL, 1'b1, 32'(c));
      rchk(ADDR_CTRL, 32'(c), "ctrl readback");
      repeat (2) @(posedge CLOCK);
      probe(m);
      chk("indicator modes", 32'(exp_modes(c)), 32'(m));
    end
    c = '0;
    c.powered = 1'b1;
    ahb(ADDR_CTRL, 1'b1, 32'(c));
    for (int n = 0; n < 4; n++) begin
      ahb(ADDR_IRQ_CLR, 1'b1, 32'h7);
      ahb(ADDR_CHG, 1'b1, 32'(n));
      r = 0;
      p = LED2_YELLOW;
      repeat (12 * FH) begin
        @(posedge CLOCK);
        r += int'(LED2_YELLOW && !p);
        p = LED2_YELLOW;
      end
      chk("changeover flashes", 32'((n == 3) ? 2 : n), 32'(r));
      ahb(ADDR_IRQ_STAT, 1'b0, 32'h0);
      chk("changeover done", 32'(n != 0), 32'(rdat[IRQ_CHG_DONE]));
    end
    tally_and_finish();
  end
endmodule : scs_top_bench
